// ### inc/hma_pkg.sv
// Purpose: constants and state layout of the halfword multiply-accumulate unit
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes:   instruction bit 0 is the least significant bit of the word
package hma_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_INSTR   = 8'h00;
    localparam logic [7:0] OFS_COND    = 8'h04;
    localparam logic [7:0] OFS_EXC     = 8'h08;
    localparam logic [7:0] OFS_IRQ_STS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h10;
    localparam logic [7:0] OFS_GPR     = 8'h80;

    // ****************************************
    // instruction fields (lsb positions)
    // ****************************************
    localparam int POS_PRIMARY = 26;
    localparam int POS_TARGET  = 21;
    localparam int POS_SRC_A   = 16;
    localparam int POS_SRC_B   = 11;
    localparam int POS_OE      = 10;
    localparam int POS_XO      = 1;
    localparam int POS_RECORD  = 0;

    localparam logic [5:0] PRIMARY_MAC = 6'h04;

    // extended opcodes
    localparam logic [8:0] XO_CROSS_SAT_S = 9'h0ec;
    localparam logic [8:0] XO_CROSS_SAT_U = 9'h0cc;
    localparam logic [8:0] XO_CROSS_MOD_U = 9'h08c;
    localparam logic [8:0] XO_HIGH_MOD_S  = 9'h02c;
    localparam logic [8:0] XO_HIGH_SAT_S  = 9'h06c;
    localparam logic [8:0] XO_HIGH_SAT_U  = 9'h04c;
    localparam logic [8:0] XO_HIGH_MOD_U  = 9'h00c;
    localparam logic [8:0] XO_LOW_MOD_S   = 9'h1ac;

    // ****************************************
    // flag fields
    // ****************************************
    localparam int COND_LT = 3;
    localparam int COND_GT = 2;
    localparam int COND_EQ = 1;
    localparam int COND_SO = 0;
    localparam int EXC_SO  = 1;
    localparam int EXC_OV  = 0;
    localparam int EV_DONE = 0;
    localparam int EV_OVF  = 1;
    localparam int EV_ILL  = 2;

    localparam logic [31:0] SAT_NEG = 32'h80000000;
    localparam logic [31:0] SAT_POS = 32'h7fffffff;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] RST_INSTR = 32'h00000000;
    localparam logic [3:0]  RST_COND  = 4'h0;
    localparam logic [1:0]  RST_EXC   = 2'h0;
    localparam logic [2:0]  RST_STS   = 3'h0;
    localparam logic [2:0]  RST_MSK   = 3'h0;

    typedef struct packed {
        logic              ack;
        logic [31:0]       dat;
        logic [31:0]       instr;
        logic              pend;
        logic [3:0]        cond;
        logic [1:0]        exc;
        logic [2:0]        sts;
        logic [2:0]        msk;
        logic              irq;
        logic [31:0][31:0] gpr;
    } hma_state_t;

endpackage

// ### rtl/hma_unit.sv
// Purpose: halfword multiply-accumulate execution unit with register file
// Assumes: classic Wishbone slave, single clock, synchronous reset
// Notes:   a write to the instruction register runs it one cycle later
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps

module hma_unit (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq
);

    hma_pkg::hma_state_t s_r;
    hma_pkg::hma_state_t s_nxt;

    // ****************************************
    // decode of the held instruction
    // ****************************************
    logic [5:0]  f_primary;
    logic [4:0]  f_target;
    logic [4:0]  f_src_a;
    logic [4:0]  f_src_b;
    logic        f_oe;
    logic [8:0]  f_xo;
    logic        f_record;

    assign f_primary = s_r.instr[hma_pkg::POS_PRIMARY +: 6];
    assign f_target  = s_r.instr[hma_pkg::POS_TARGET +: 5];
    assign f_src_a   = s_r.instr[hma_pkg::POS_SRC_A +: 5];
    assign f_src_b   = s_r.instr[hma_pkg::POS_SRC_B +: 5];
    assign f_oe      = s_r.instr[hma_pkg::POS_OE];
    assign f_xo      = s_r.instr[hma_pkg::POS_XO +: 9];
    assign f_record  = s_r.instr[hma_pkg::POS_RECORD];

    logic legal;
    logic hi_a;
    logic hi_b;
    logic sgn;
    logic sat;

    always_comb begin
        legal = 1'b1;
        hi_a  = 1'b0;
        hi_b  = 1'b1;
        sgn   = 1'b0;
        sat   = 1'b0;
        case (f_xo)
            hma_pkg::XO_CROSS_SAT_S: begin
                sgn = 1'b1;
                sat = 1'b1;
            end
            hma_pkg::XO_CROSS_SAT_U: begin
                sat = 1'b1;
            end
            hma_pkg::XO_CROSS_MOD_U: begin
                sat = 1'b0;
            end
            hma_pkg::XO_HIGH_MOD_S: begin
                hi_a = 1'b1;
                sgn  = 1'b1;
            end
            hma_pkg::XO_HIGH_SAT_S: begin
                hi_a = 1'b1;
                sgn  = 1'b1;
                sat  = 1'b1;
            end
            hma_pkg::XO_HIGH_SAT_U: begin
                hi_a = 1'b1;
                sat  = 1'b1;
            end
            hma_pkg::XO_HIGH_MOD_U: begin
                hi_a = 1'b1;
            end
            hma_pkg::XO_LOW_MOD_S: begin
                hi_b = 1'b0;
                sgn  = 1'b1;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
        if (f_primary != hma_pkg::PRIMARY_MAC) begin
            legal = 1'b0;
        end
    end

    // ****************************************
    // multiply, accumulate, saturate
    // ****************************************
    logic [31:0] acc_old;
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic [15:0] half_a;
    logic [15:0] half_b;
    logic [31:0] prod_s;
    logic [31:0] prod_u;
    logic [31:0] prod;
    logic [32:0] sum;
    logic        sov;
    logic        ovf;
    logic [31:0] res;

    // accumulator read from registered state, written back only at the edge
    assign acc_old = s_r.gpr[f_target];
    assign op_a    = s_r.gpr[f_src_a];
    assign op_b    = s_r.gpr[f_src_b];
    assign half_a  = hi_a ? op_a[31:16] : op_a[15:0];
    assign half_b  = hi_b ? op_b[31:16] : op_b[15:0];
    assign prod_s  = 32'($signed(half_a) * $signed(half_b));
    assign prod_u  = 32'(half_a * half_b);
    assign prod    = sgn ? prod_s : prod_u;

    always_comb begin
        if (sgn) begin
            sum = {prod[31], prod} + {acc_old[31], acc_old};
        end else begin
            sum = {1'b0, prod} + {1'b0, acc_old};
        end
        sov = (prod[31] == acc_old[31]) && (acc_old[31] != sum[31]);
        ovf = sgn ? sov : sum[32];
        if (sat && sgn && sov) begin
            res = acc_old[31] ? hma_pkg::SAT_NEG : hma_pkg::SAT_POS;
        end else if (sat && !sgn) begin
            res = sum[31:0] | {32{sum[32]}};
        end else if (sat) begin
            res = sum[31:0];
        end else begin
            res = sum[31:0];
        end
    end

    // ****************************************
    // bus decode, execution, flags
    // ****************************************
    logic        req;
    logic        wr_now;
    logic [31:0] rd_val;
    logic [2:0]  ev;
    logic [2:0]  clr;
    logic        so_new;
    logic [31:0] wmask;

    assign req    = wb_cyc_i && wb_stb_i;
    assign wr_now = req && wb_we_i && s_r.ack;
    assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        if (wb_adr_i == hma_pkg::OFS_INSTR) begin
            rd_val = s_r.instr;
        end else if (wb_adr_i == hma_pkg::OFS_COND) begin
            rd_val = {28'h0000000, s_r.cond};
        end else if (wb_adr_i == hma_pkg::OFS_EXC) begin
            rd_val = {30'h0, s_r.exc};
        end else if (wb_adr_i == hma_pkg::OFS_IRQ_STS) begin
            rd_val = {29'h0, s_r.sts};
        end else if (wb_adr_i == hma_pkg::OFS_IRQ_MSK) begin
            rd_val = {29'h0, s_r.msk};
        end else if (wb_adr_i[7]) begin
            rd_val = s_r.gpr[wb_adr_i[6:2]];
        end else begin
            rd_val = 32'h00000000;
        end
    end

    always_comb begin
        s_nxt  = s_r;
        ev     = 3'h0;
        clr    = 3'h0;
        so_new = s_r.exc[hma_pkg::EXC_SO];

        s_nxt.ack  = req && !s_r.ack;
        s_nxt.pend = 1'b0;
        if (req && !s_r.ack) begin
            s_nxt.dat = rd_val;
        end

        if (wr_now) begin
            if (wb_adr_i == hma_pkg::OFS_INSTR) begin
                s_nxt.instr = (s_r.instr & ~wmask) | (wb_dat_i & wmask);
                s_nxt.pend  = 1'b1;
            end else if (wb_adr_i == hma_pkg::OFS_COND) begin
                if (wb_sel_i[0]) begin
                    s_nxt.cond = wb_dat_i[3:0];
                end
            end else if (wb_adr_i == hma_pkg::OFS_EXC) begin
                if (wb_sel_i[0]) begin
                    s_nxt.exc = wb_dat_i[1:0];
                end
            end else if (wb_adr_i == hma_pkg::OFS_IRQ_STS) begin
                if (wb_sel_i[0]) begin
                    clr = wb_dat_i[2:0];
                end
            end else if (wb_adr_i == hma_pkg::OFS_IRQ_MSK) begin
                if (wb_sel_i[0]) begin
                    s_nxt.msk = wb_dat_i[2:0];
                end
            end else if (wb_adr_i[7]) begin
                s_nxt.gpr[wb_adr_i[6:2]] = (s_r.gpr[wb_adr_i[6:2]] & ~wmask)
                                           | (wb_dat_i & wmask);
            end
        end

        if (s_r.pend && !legal) begin
            ev[hma_pkg::EV_ILL] = 1'b1;
        end else if (s_r.pend) begin
            s_nxt.gpr[f_target] = res;
            ev[hma_pkg::EV_DONE] = 1'b1;
            ev[hma_pkg::EV_OVF]  = ovf;
            if (f_oe) begin
                so_new = s_r.exc[hma_pkg::EXC_SO] | ovf;
                s_nxt.exc[hma_pkg::EXC_OV] = ovf;
                s_nxt.exc[hma_pkg::EXC_SO] = so_new;
            end
            if (f_record) begin
                s_nxt.cond[hma_pkg::COND_LT] = res[31];
                s_nxt.cond[hma_pkg::COND_GT] = !res[31] && (res != 32'h0);
                s_nxt.cond[hma_pkg::COND_EQ] = (res == 32'h0);
                s_nxt.cond[hma_pkg::COND_SO] = so_new;
            end
        end

        // set wins over a same-cycle clear
        s_nxt.sts = (s_r.sts & ~clr) | ev;
        s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r       <= '0;
            s_r.instr <= hma_pkg::RST_INSTR;
            s_r.cond  <= hma_pkg::RST_COND;
            s_r.exc   <= hma_pkg::RST_EXC;
            s_r.sts   <= hma_pkg::RST_STS;
            s_r.msk   <= hma_pkg::RST_MSK;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    assign irq      = s_r.irq;

endmodule

// ### verification/hma_chk.sv
// Purpose: bus and interrupt timing checks on the hma_unit ports
// Assumes: classic single-cycle bus master, one clock domain
// Notes:   bound to every hma_unit instance
`timescale 1ns/1ps
module hma_chk (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire req = wb_cyc_i && wb_stb_i;
    wire wak = wb_we_i && wb_ack_o;
    property p_ack_next; req && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ack_cause; wb_ack_o |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_rst; $fell(rst) |-> !wb_ack_o && !irq && wb_dat_o == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_unmap;
        req && !wb_we_i && wb_adr_i == 8'h40 && !wb_ack_o |=> wb_dat_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_dat_hold; !req |=> $stable(wb_dat_o); endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    property p_irq_up; $rose(irq) |-> $past(wak) || $past(wak, 2); endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq rose alone");
    property p_irq_down; $fell(irq) |-> $past(wak) || $past(wak, 2); endproperty
    a_irq_down: assert property (p_irq_down) else $error("irq fell alone");
    c_irq: cover property ($rose(irq));
    c_wr: cover property (wak);
    c_rd: cover property (wb_ack_o && !wb_we_i);
endmodule
bind hma_unit hma_chk u_chk (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

// ### verification/hma_wb_host.sv
// Purpose: classic bus master standing in for the decoder side
// Assumes: xfer is entered just after a rising edge
// Notes:   released address, lanes and write data are inverted, never left as they were
`timescale 1ns/1ps
module hma_wb_host (
    input  wire logic        clock,
    input  wire logic        ack,
    input  wire logic [31:0] rdat,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [7:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      wdat
);
    initial begin
        {cyc, stb, we, adr, sel, wdat} = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q, output bit ok);
        int n;
        n = 0;
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 64);
        q = rdat;
        ok = ack === 1'b1;
        {cyc, stb, we} <= 3'h0;
        {adr, sel} <= ~{a, s};
        wdat <= ~d;
        @(posedge clock);
    endtask
endmodule

// ### verification/tb.sv
// Purpose: self-checking bench for hma_unit
// Assumes: hma_wb_host drives the register bus
// Notes:   expected results come from the local mac model
`timescale 1ns/1ps
module tb;
    // mode: [3] a high half, [2] b low half, [1] signed, [0] saturating
    typedef struct packed { logic [8:0] xo; logic [3:0] mode; } hma_op_t;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic        cyc, stb, we, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    int          n_fail = 0;
    int          check_count = 0;
    // primary 4 with an undefined extended opcode, oe and record set
    localparam logic [31:0] BAD_XO = {hma_pkg::PRIMARY_MAC, 5'd31, 5'd1, 5'd2, 1'b1,
                                      9'h1ff, 1'b1};
    hma_op_t     ops [8] = '{
        '{hma_pkg::XO_CROSS_SAT_S, 4'b0011},
        '{hma_pkg::XO_CROSS_SAT_U, 4'b0001},
        '{hma_pkg::XO_CROSS_MOD_U, 4'b0000},
        '{hma_pkg::XO_HIGH_MOD_S, 4'b1010},
        '{hma_pkg::XO_HIGH_SAT_S, 4'b1011},
        '{hma_pkg::XO_HIGH_SAT_U, 4'b1001},
        '{hma_pkg::XO_HIGH_MOD_U, 4'b1000},
        '{hma_pkg::XO_LOW_MOD_S, 4'b0110}};
    logic [31:0] av [3] = '{32'h80017fff, 32'h00038000, 32'hffffffff};
    logic [31:0] bv [3] = '{32'h7fff8000, 32'h7ffffffd, 32'hffffffff};
    logic [31:0] tv [3] = '{32'h7ffffff0, 32'h80000010, 32'hffffff00};
    always #4 clock = ~clock;
    hma_unit uut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq(irq));
    hma_wb_host host (.clock(clock), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .sel(sel), .wdat(wdat));
    task automatic end_sim;
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] q);
        bit ok;
        host.xfer(w, a, s, d, q, ok);
        if (!ok) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic wr_sel(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, s, d, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wr_sel(a, 4'hf, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 4'hf, 32'h0, q);
        chk(q, e);
    endtask
    // returns {overflow, result}
    function automatic logic [32:0] mac(input hma_op_t o, input logic [31:0] a,
                                        input logic [31:0] b, input logic [31:0] t);
        logic [15:0] x;
        logic [15:0] y;
        logic [31:0] p;
        logic [32:0] s;
        logic        ov;
        x = o.mode[3] ? a[31:16] : a[15:0];
        y = o.mode[2] ? b[15:0] : b[31:16];
        p = {{16{o.mode[1] & x[15]}}, x} * {{16{o.mode[1] & y[15]}}, y};
        s = {1'b0, p} + {1'b0, t};
        ov = o.mode[1] ? (p[31] == t[31] && s[31] != t[31]) : s[32];
        if (o.mode[0] && ov)
            return {ov, o.mode[1] ? (t[31] ? hma_pkg::SAT_NEG : hma_pkg::SAT_POS) : 32'hffffffff};
        return {ov, s[31:0]};
    endfunction
    initial begin
        logic [32:0] e;
        logic [3:0]  cnd;
        logic [1:0]  exc;
        logic [2:0]  sts;
        cnd = 4'h0;
        exc = 2'h0;
        sts = 3'h0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd_chk(hma_pkg::OFS_COND, 32'(hma_pkg::RST_COND));
        rd_chk(hma_pkg::OFS_EXC, 32'(hma_pkg::RST_EXC));
        rd_chk(hma_pkg::OFS_IRQ_MSK, 32'(hma_pkg::RST_MSK));
        rd_chk(8'h40, 32'h0);
        wr(8'h44, 32'hffffffff);
        rd_chk(8'h44, 32'h0);
        rd_chk(hma_pkg::OFS_IRQ_STS, 32'(hma_pkg::RST_STS));
        rd_chk(hma_pkg::OFS_INSTR, hma_pkg::RST_INSTR);
        wr(hma_pkg::OFS_COND, 32'h0000000a);
        wr_sel(hma_pkg::OFS_COND, 4'he, 32'h00000005);
        rd_chk(hma_pkg::OFS_COND, 32'h0000000a);
        wr(hma_pkg::OFS_EXC, 32'h00000003);
        rd_chk(hma_pkg::OFS_EXC, 32'h00000003);
        wr(hma_pkg::OFS_COND, 32'h0);
        wr(hma_pkg::OFS_EXC, 32'h0);
        wr(hma_pkg::OFS_GPR + 8'h0c, 32'hffffffff);
        wr_sel(hma_pkg::OFS_GPR + 8'h0c, 4'h5, 32'h12345678);
        rd_chk(hma_pkg::OFS_GPR + 8'h0c, 32'hff34ff78);
        for (int i = 0; i < 24; i++) begin
            wr(hma_pkg::OFS_GPR + 8'h04, av[i % 3]);
            wr(hma_pkg::OFS_GPR + 8'h08, bv[i % 3]);
            wr(hma_pkg::OFS_GPR + 8'h7c, tv[i % 3]);
            wr(hma_pkg::OFS_INSTR, {hma_pkg::PRIMARY_MAC, 5'd31, 5'd1, 5'd2, i[1],
                ops[i / 3].xo, i[0]});
            e = mac(ops[i / 3], av[i % 3], bv[i % 3], tv[i % 3]);
            sts = sts | {1'b0, e[32], 1'b1};
            if (i[1])
                exc = {exc[1] | e[32], e[32]};
            if (i[0])
                cnd = {e[31], !e[31] && e[31:0] != 32'h0, e[31:0] == 32'h0, exc[1]};
            rd_chk(hma_pkg::OFS_GPR + 8'h7c, e[31:0]);
            rd_chk(hma_pkg::OFS_COND, {28'h0, cnd});
            rd_chk(hma_pkg::OFS_EXC, {30'h0, exc});
        end
        chk(32'(irq), 32'h0);
        rd_chk(hma_pkg::OFS_IRQ_STS, {29'h0, sts});
        wr(hma_pkg::OFS_IRQ_MSK, 32'h1);
        rd_chk(hma_pkg::OFS_IRQ_MSK, 32'h1);
        chk(32'(irq), 32'h1);
        wr(hma_pkg::OFS_IRQ_STS, 32'h1);
        rd_chk(hma_pkg::OFS_IRQ_STS, {29'h0, sts & 3'b010});
        chk(32'(irq), 32'h0);
        wr(hma_pkg::OFS_INSTR, 32'h0);
        rd_chk(hma_pkg::OFS_IRQ_STS, {29'h0, (sts & 3'b010) | 3'b100});
        rd_chk(hma_pkg::OFS_GPR + 8'h7c, e[31:0]);
        chk(32'(irq), 32'h0);
        wr(hma_pkg::OFS_IRQ_STS, 32'h4);
        wr(hma_pkg::OFS_INSTR, BAD_XO);
        rd_chk(hma_pkg::OFS_INSTR, BAD_XO);
        rd_chk(hma_pkg::OFS_IRQ_STS, {29'h0, (sts & 3'b010) | 3'b100});
        rd_chk(hma_pkg::OFS_GPR + 8'h7c, e[31:0]);
        rd_chk(hma_pkg::OFS_COND, {28'h0, cnd});
        rd_chk(hma_pkg::OFS_EXC, {30'h0, exc});
        wr(hma_pkg::OFS_IRQ_MSK, 32'h4);
        rd_chk(hma_pkg::OFS_IRQ_MSK, 32'h4);
        chk(32'(irq), 32'h1);
        wr(hma_pkg::OFS_IRQ_STS, 32'h7);
        rd_chk(hma_pkg::OFS_IRQ_STS, 32'h0);
        chk(32'(irq), 32'h0);
        wr(hma_pkg::OFS_IRQ_MSK, 32'h7);
        wr(hma_pkg::OFS_INSTR, 32'h0);
        rd_chk(hma_pkg::OFS_IRQ_STS, 32'h4);
        chk(32'(irq), 32'h1);
        // mid-run reset, held past the edge at which irq falls
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk(32'(irq), 32'h0);
        rd_chk(hma_pkg::OFS_GPR + 8'h7c, 32'h0);
        rd_chk(hma_pkg::OFS_COND, 32'(hma_pkg::RST_COND));
        rd_chk(hma_pkg::OFS_EXC, 32'(hma_pkg::RST_EXC));
        rd_chk(hma_pkg::OFS_IRQ_STS, 32'(hma_pkg::RST_STS));
        rd_chk(hma_pkg::OFS_IRQ_MSK, 32'(hma_pkg::RST_MSK));
        end_sim();
    end
endmodule
